// ---- src/bld_pkg.sv ----
// Purpose : Shared constants and types for the backlight dimming link
// Assumes : 125 MHz mclk on both ends, single enable wire
// Notes   : Times kept in their own unit, cycle counts derived from them
`default_nettype none

package bld_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ         = 125;
  localparam int ENABLE_MIN_NS   = 40000;    // Least initial high time
  localparam int PULSE_MIN_NS    = 500;      // Shortest dimming low pulse
  localparam int PULSE_MAX_NS    = 500000;   // Longest dimming low pulse
  localparam int SHUTDOWN_NS     = 1330000;  // Low time that shuts down
  localparam int SOFT_START_NS   = 100000;   // Soft-start ramp length
  localparam int PWM_MIN_KHZ     = 30;
  localparam int PWM_MAX_KHZ     = 500;

  localparam int ENABLE_MIN_CYC  = (ENABLE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MIN_CYC   = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MAX_CYC   = (PULSE_MAX_NS * CLK_MHZ) / 1000;
  localparam int SHUTDOWN_CYC    = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
  localparam int SOFT_START_CYC  = (SOFT_START_NS * CLK_MHZ) / 1000;
  // PWM period cycles at the fast and slow ends of the recommended band
  localparam int PWM_PER_MIN_CYC = (CLK_MHZ * 1000 + PWM_MAX_KHZ - 1)
                                   / PWM_MAX_KHZ;
  localparam int PWM_PER_MAX_CYC = (CLK_MHZ * 1000) / PWM_MIN_KHZ;

  localparam int CNT_W           = 18;       // Holds SHUTDOWN_CYC

  // ****************************************
  // Current scale
  // ****************************************
  localparam int LEVEL_W         = 6;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 6'h21;  // 33 units, 24.75 mA
  localparam logic [LEVEL_W-1:0] LEVEL_MIN  = 6'h01;  // 1/33 of full
  localparam logic [LEVEL_W-1:0] LEVEL_OFF  = 6'h00;
  localparam int STEP_UA         = 750;      // One unit in microamps
  localparam int DUTY_W          = 8;
  localparam logic [DUTY_W-1:0]  DUTY_FULL  = 8'hff;

  // ****************************************
  // Device and host states
  // ****************************************
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_ARMING   = 3'b001,
    ST_SOFT     = 3'b010,
    ST_RUN      = 3'b011,
    ST_LATCHED  = 3'b100
  } bld_state_type;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_LOW   = 2'b01,
    HS_HIGH  = 2'b10
  } bld_host_state_type;

endpackage : bld_pkg

`default_nettype wire

// ---- src/bld_link_if.sv ----
// Purpose : Carrier for the single enable wire between host and device
// Assumes : One clock shared by both ends
// Notes   : Host is the only driver, so no enable pairing is needed
`default_nettype none

interface bld_link_if;
  logic enableLine;  // Enable and dimming wire

  modport host   (output enableLine);
  modport device (input  enableLine);
endinterface : bld_link_if

`default_nettype wire

// ---- src/bld_device.sv ----
// Purpose : Device end: decodes the enable wire into state and current
// Assumes : Enable wire is asynchronous to mclk; 125 MHz clock
// Notes   : Variant chosen by pulseVariant, sampled only while shut down
`default_nettype none

// Contract
// R01 - PWM variant: current follows duty cycle
// R02 - Host keeps PWM between 30 and 500 kHz
// R03 - Steady high enables, steady low shuts down
// R04 - 40us high enables, soft-start to full
// R05 - Dimming low pulses 500ns-500us after soft-start
// R06 - Each accepted pulse lowers one 0.75mA step
// R07 - Full scale is 24.75mA after soft-start
// R08 - Never below one thirty-third of full
// R09 - Low for 1.33ms shuts down
// R10 - Thirty-two equal steps below full scale
// R11 - Shutdown clears soft-start for next enable
// R12 - Overvoltage latch holds off until toggle
// R13 - Overlong low pulse counts as one step
module bld_device
  import bld_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  bld_link_if.device              link,
  input  wire logic               pulseVariant,
  input  wire logic               overvoltageIn,
  output logic                    ledActive,
  output logic                    softStartBusy,
  output logic [LEVEL_W-1:0]      pulseLevel,
  output logic [DUTY_W-1:0]       pwmDuty,
  output logic                    overvoltageLatched
);

  // ****************************************
  // Input synchroniser
  // ****************************************
  logic syncA_reg;
  logic syncB_reg;
  logic lineLast_reg;

  // Two stages because the wire comes from another domain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg    <= 1'b0;
      syncB_reg    <= 1'b0;
      lineLast_reg <= 1'b0;
    end else begin
      syncA_reg    <= link.enableLine;
      syncB_reg    <= syncA_reg;
      lineLast_reg <= syncB_reg;
    end
  end

  logic lineFall;
  logic lineRise;
  assign lineFall = lineLast_reg & ~syncB_reg;
  assign lineRise = ~lineLast_reg & syncB_reg;

  // ****************************************
  // Level timers
  // ****************************************
  logic [CNT_W-1:0] lowCnt_reg;
  logic [CNT_W-1:0] highCnt_reg;
  logic             longLow;

  // Saturating counters of time spent low and high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_reg  <= '0;
      highCnt_reg <= '0;
    end else begin
      if (syncB_reg) begin
        lowCnt_reg <= '0;
      end else if (lowCnt_reg != CNT_W'(SHUTDOWN_CYC)) begin
        lowCnt_reg <= lowCnt_reg + 1'b1;
      end
      if (!syncB_reg) begin
        highCnt_reg <= '0;
      end else if (highCnt_reg != CNT_W'(ENABLE_MIN_CYC)) begin
        highCnt_reg <= highCnt_reg + 1'b1;
      end
    end
  end

  assign longLow = (lowCnt_reg == CNT_W'(SHUTDOWN_CYC));  // R09

  // ****************************************
  // Mode state machine
  // ****************************************
  bld_state_type    state_reg;
  bld_state_type    state_next;
  logic             variant_reg;
  logic [CNT_W-1:0] softCnt_reg;
  logic             softDone;

  assign softDone = (softCnt_reg == CNT_W'(SOFT_START_CYC));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUTDOWN: begin
        if (syncB_reg) begin
          state_next = variant_reg ? ST_ARMING : ST_SOFT;  // R03
        end
      end
      ST_ARMING: begin
        if (!syncB_reg) begin
          state_next = ST_SHUTDOWN;
        end else if (highCnt_reg == CNT_W'(ENABLE_MIN_CYC)) begin
          state_next = ST_SOFT;  // R04
        end
      end
      ST_SOFT: begin
        if (longLow) begin
          state_next = ST_SHUTDOWN;  // R09
        end else if (softDone) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (longLow) begin
          state_next = ST_SHUTDOWN;  // R09
        end
      end
      ST_LATCHED: begin
        // Only a low level followed by high restarts
        if (lineRise) begin
          state_next = variant_reg ? ST_ARMING : ST_SOFT;  // R12
        end
      end
      default: begin
        state_next = ST_SHUTDOWN;
      end
    endcase
    if (overvoltageIn) begin
      state_next = ST_LATCHED;  // R12
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Variant is frozen while running so a strap glitch cannot switch modes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      variant_reg <= 1'b0;
    end else if (state_reg == ST_SHUTDOWN) begin
      variant_reg <= pulseVariant;
    end
  end

  // Soft-start timer restarts on every entry into ST_SOFT
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      softCnt_reg <= '0;
    end else if (state_reg != ST_SOFT) begin
      softCnt_reg <= '0;  // R11
    end else if (!softDone) begin
      softCnt_reg <= softCnt_reg + 1'b1;
    end
  end

  // ****************************************
  // Pulse dimming level
  // ****************************************
  // A low pulse is counted at its rising edge, so the length is known;
  // any length from the minimum up to shutdown time counts once, overlong ones included.
  logic pulseOk;
  assign pulseOk = lineRise && (lowCnt_reg >= CNT_W'(PULSE_MIN_CYC - 3));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulseLevel <= LEVEL_OFF;
    end else if (!variant_reg || state_next == ST_SHUTDOWN
                 || state_next == ST_LATCHED
                 || state_next == ST_ARMING) begin
      pulseLevel <= LEVEL_OFF;
    end else if (state_next == ST_SOFT) begin
      pulseLevel <= LEVEL_FULL;  // R07
    end else if (state_reg == ST_RUN && pulseOk) begin  // R05 R13
      if (pulseLevel > LEVEL_MIN) begin
        pulseLevel <= pulseLevel - 1'b1;  // R06 R10
      end else begin
        pulseLevel <= LEVEL_MIN;  // R08
      end
    end
  end

  // ****************************************
  // Duty-cycle measurement
  // ****************************************
  logic [CNT_W-1:0] perCnt_reg;
  logic [CNT_W-1:0] hiAcc_reg;
  logic [CNT_W+DUTY_W-1:0] scaled;

  assign scaled = {hiAcc_reg, {DUTY_W{1'b0}}} - {{DUTY_W{1'b0}}, hiAcc_reg};

  // One period is rise to rise; duty = high time / period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      perCnt_reg <= '0;
      hiAcc_reg  <= '0;
      pwmDuty    <= '0;
    end else if (variant_reg || state_next == ST_SHUTDOWN
                 || state_next == ST_LATCHED) begin
      perCnt_reg <= '0;
      hiAcc_reg  <= '0;
      pwmDuty    <= '0;
    end else if (lineRise) begin
      // A rise after a steady level only opens a period, so no
      // partial period ever reaches the duty output
      if (perCnt_reg != '0) begin
        pwmDuty <= DUTY_W'(scaled / {{DUTY_W{1'b0}}, perCnt_reg});  // R01
      end
      perCnt_reg <= CNT_W'(1);
      hiAcc_reg  <= CNT_W'(1);
    end else if (lowCnt_reg == CNT_W'(PWM_PER_MAX_CYC)
                 || (syncB_reg && highCnt_reg == CNT_W'(ENABLE_MIN_CYC))) begin
      // Steady level: pure on/off behaviour
      pwmDuty    <= syncB_reg ? DUTY_FULL : '0;  // R03
      perCnt_reg <= '0;
      hiAcc_reg  <= '0;
    end else if (perCnt_reg != '0 && perCnt_reg != '1) begin
      perCnt_reg <= perCnt_reg + 1'b1;
      hiAcc_reg  <= hiAcc_reg + CNT_W'(syncB_reg);
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ledActive          <= 1'b0;
      softStartBusy      <= 1'b0;
      overvoltageLatched <= 1'b0;
    end else begin
      ledActive          <= (state_next == ST_SOFT)
                            || (state_next == ST_RUN);
      softStartBusy      <= (state_next == ST_SOFT);
      overvoltageLatched <= (state_next == ST_LATCHED);
    end
  end

endmodule : bld_device

`default_nettype wire

// ---- src/bld_host.sv ----
// Purpose : Host end: drives the enable wire from user commands
// Assumes : Same mclk as the device; commands pulse one cycle
// Notes   : Dim pulses after cmdEnable are held off until the device's soft-start is over
`default_nettype none

module bld_host
  import bld_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  bld_link_if.host                link,
  input  wire logic               cmdEnable,
  input  wire logic               cmdDim,
  input  wire logic               cmdOff,
  input  wire logic               pwmMode,
  input  wire logic [DUTY_W-1:0]  pwmDutyIn,
  output logic                    busy
);

  // ****************************************
  // Command sequencer
  // ****************************************
  bld_host_state_type hstate_reg;
  logic [CNT_W-1:0]   holdCnt_reg;
  logic [CNT_W-1:0]   lowTarget_reg;
  logic               line_reg;
  logic               enabled_reg;  // Enabled, independent of wire level
  logic [CNT_W-1:0]   pwmCnt_reg;
  logic [CNT_W-1:0]   hiCyc;

  assign link.enableLine = line_reg;
  // High time of one PWM period at the fastest legal rate; R02
  assign hiCyc = CNT_W'((32'(pwmDutyIn) * PWM_PER_MIN_CYC) / 255);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hstate_reg    <= HS_IDLE;
      holdCnt_reg   <= '0;
      lowTarget_reg <= '0;
      line_reg      <= 1'b0;
      enabled_reg   <= 1'b0;
      busy          <= 1'b0;
      pwmCnt_reg    <= '0;
    end else begin
      case (hstate_reg)
        HS_IDLE: begin
          busy <= 1'b0;
          if (pwmMode && enabled_reg && !cmdOff) begin
            // Free-running PWM while enabled; the wire's own level
            // cannot gate it or the first low phase would stall it
            pwmCnt_reg <= (pwmCnt_reg >= CNT_W'(PWM_PER_MIN_CYC - 1))
                          ? '0 : pwmCnt_reg + 1'b1;
            line_reg   <= (pwmCnt_reg < hiCyc);  // R01 R02
          end
          if (cmdOff) begin
            line_reg      <= 1'b0;
            enabled_reg   <= 1'b0;
            lowTarget_reg <= CNT_W'(SHUTDOWN_CYC);  // R09
            holdCnt_reg   <= '0;
            busy          <= 1'b1;
            hstate_reg    <= HS_LOW;
          end else if (cmdEnable) begin
            line_reg    <= 1'b1;  // R03 R04
            enabled_reg <= 1'b1;
            holdCnt_reg <= '0;
            pwmCnt_reg  <= '0;
            busy        <= 1'b1;
            hstate_reg  <= HS_HIGH;
          end else if (cmdDim && !pwmMode) begin
            line_reg      <= 1'b0;
            lowTarget_reg <= CNT_W'(PULSE_MIN_CYC * 2);  // R05
            holdCnt_reg   <= '0;
            busy          <= 1'b1;
            hstate_reg    <= HS_LOW;
          end
        end
        HS_LOW: begin
          holdCnt_reg <= holdCnt_reg + 1'b1;
          if (holdCnt_reg == lowTarget_reg) begin
            line_reg   <= (lowTarget_reg != CNT_W'(SHUTDOWN_CYC));
            hstate_reg <= HS_IDLE;
          end
        end
        HS_HIGH: begin
          // Hold past enable time plus soft-start before any dimming
          holdCnt_reg <= holdCnt_reg + 1'b1;
          if (holdCnt_reg == CNT_W'(ENABLE_MIN_CYC + SOFT_START_CYC + 8)) begin
            hstate_reg <= HS_IDLE;  // R05
          end
        end
        default: begin
          hstate_reg <= HS_IDLE;
        end
      endcase
    end
  end

endmodule : bld_host

`default_nettype wire

// ---- test/bld_link_chk.sv ----
// Purpose : Concurrent checks on the enable wire and device outputs
// Assumes : One clock, resetn asynchronous active low
// Notes   : Wire history is counted here; no bind, tb instantiates it
`default_nettype none

module bld_link_chk
  import bld_pkg::*;
(
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic               enableLine,
  input wire logic               pulseVariant,
  input wire logic               overvoltageIn,
  input wire logic               ledActive,
  input wire logic               softStartBusy,
  input wire logic [LEVEL_W-1:0] pulseLevel,
  input wire logic [DUTY_W-1:0]  pwmDuty,
  input wire logic               overvoltageLatched
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Helper counters
  // ****************************************
  logic [CNT_W-1:0] hiCnt_reg;
  logic [CNT_W-1:0] loCnt_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // High run length; saturates so a long run never wraps to zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) hiCnt_reg <= '0;
    else if (!enableLine) hiCnt_reg <= '0;
    else if (hiCnt_reg != '1) hiCnt_reg <= hiCnt_reg + 1'b1;
  end

  // Low run length
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) loCnt_reg <= '0;
    else if (enableLine) loCnt_reg <= '0;
    else if (loCnt_reg != '1) loCnt_reg <= loCnt_reg + 1'b1;
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_full_max;
    pulseLevel <= LEVEL_FULL;
  endproperty
  a_full_max: assert property (p_full_max)
    else $error("pulse level above full scale");

  property p_soft_full;
    pulseVariant && $rose(softStartBusy) |-> pulseLevel == LEVEL_FULL;
  endproperty
  a_soft_full: assert property (p_soft_full)
    else $error("soft-start did not begin at full scale");

  property p_enable_min;
    pulseVariant && $rose(softStartBusy) |-> hiCnt_reg >= ENABLE_MIN_CYC;
  endproperty
  a_enable_min: assert property (p_enable_min)
    else $error("soft-start began after too short a high time");

  // Only a hold or a single step down while running
  property p_step;
    pulseVariant && ledActive && $past(ledActive) |->
      (pulseLevel == $past(pulseLevel) ||
       pulseLevel == $past(pulseLevel) - 6'h01);
  endproperty
  a_step: assert property (p_step)
    else $error("pulse level moved by other than one step");

  property p_floor;
    pulseVariant && ledActive |-> pulseLevel >= LEVEL_MIN;
  endproperty
  a_floor: assert property (p_floor)
    else $error("pulse level below the minimum");

  property p_ovl;
    overvoltageIn |=> overvoltageLatched && !ledActive;
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overvoltage did not latch the device off");

  property p_latch_hold;
    overvoltageLatched && enableLine && $past(enableLine) &&
      $past(enableLine, 2) && $past(enableLine, 3) &&
      $past(enableLine, 4) && $past(enableLine, 5) |=> overvoltageLatched;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch released without a toggle of the wire");

  property p_shut;
    loCnt_reg >= SHUTDOWN_CYC + 8 |-> !ledActive && !softStartBusy &&
      pulseLevel == LEVEL_OFF;
  endproperty
  a_shut: assert property (p_shut)
    else $error("device still on after a long low");

  property p_pwm_zero;
    pulseVariant |-> pwmDuty == 8'h00;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero)
    else $error("duty output active in pulse variant");

  property p_lvl_zero;
    !pulseVariant |-> pulseLevel == LEVEL_OFF;
  endproperty
  a_lvl_zero: assert property (p_lvl_zero)
    else $error("pulse level active in duty variant");

  // Main scenarios reached
  c_soft: cover property ($rose(softStartBusy));
  c_floor: cover property (ledActive && pulseLevel == LEVEL_MIN);
  c_latch: cover property ($rose(overvoltageLatched));
  c_pwm: cover property (!pulseVariant && pwmDuty == DUTY_FULL);
endmodule : bld_link_chk

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose : Self-checking bench joining host and device on one wire
// Assumes : 125 MHz mclk, inputs driven on the falling edge
// Notes   : Full shutdown time is run once; counts are not shortened
`default_nettype none

module tb_top
  import bld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk = 1'b0;
  logic               resetn = 1'b0;
  logic               pulseVariant = 1'b1;
  logic               overvoltageIn = 1'b0;
  logic               cmdEnable = 1'b0;
  logic               cmdDim = 1'b0;
  logic               cmdOff = 1'b0;
  logic               pwmMode = 1'b0;
  logic [DUTY_W-1:0]  pwmDutyIn = 8'h00;
  logic               ledActive, softStartBusy, overvoltageLatched, busy;
  logic [LEVEL_W-1:0] pulseLevel;
  logic [DUTY_W-1:0]  pwmDuty;
  int                 failures = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  bld_link_if u_bld_link_if ();

  bld_host u_bld_host (.mclk(mclk), .resetn(resetn), .link(u_bld_link_if),
    .cmdEnable(cmdEnable), .cmdDim(cmdDim), .cmdOff(cmdOff),
    .pwmMode(pwmMode), .pwmDutyIn(pwmDutyIn), .busy(busy));

  bld_device u_bld_device (.mclk(mclk), .resetn(resetn),
    .link(u_bld_link_if), .pulseVariant(pulseVariant),
    .overvoltageIn(overvoltageIn), .ledActive(ledActive),
    .softStartBusy(softStartBusy), .pulseLevel(pulseLevel),
    .pwmDuty(pwmDuty), .overvoltageLatched(overvoltageLatched));

  bld_link_chk u_bld_link_chk (.mclk(mclk), .resetn(resetn),
    .enableLine(u_bld_link_if.enableLine), .pulseVariant(pulseVariant),
    .overvoltageIn(overvoltageIn), .ledActive(ledActive),
    .softStartBusy(softStartBusy), .pulseLevel(pulseLevel),
    .pwmDuty(pwmDuty), .overvoltageLatched(overvoltageLatched));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  always #4 mclk = ~mclk;

  // Ceiling covers one full shutdown plus four soft-starts
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 400000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] expV,
                       input logic [7:0] gotV);
    total_checks++;
    if (gotV !== expV) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, expV, gotV);
    end
  endtask : check

  // One command pulse, then wait for the host to go idle
  task automatic cmd(input int which);
    int n;
    @(negedge mclk);
    cmdEnable = (which == 0);
    cmdDim = (which == 1);
    cmdOff = (which == 2);
    @(negedge mclk);
    {cmdEnable, cmdDim, cmdOff} = 3'b000;
    n = 0;
    repeat (3) @(negedge mclk);
    while (busy !== 1'b0 && n < SHUTDOWN_CYC + 20000) begin
      @(negedge mclk);
      n++;
    end
    check("busy", 8'h00, {7'h00, busy});
    repeat (6) @(negedge mclk);
  endtask : cmd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_enable();
    cmd(0);
    check("ledActive", 8'h01, {7'h00, ledActive});
    check("softStartBusy", 8'h00, {7'h00, softStartBusy});
    check("pulseLevel", {2'b00, LEVEL_FULL}, {2'b00, pulseLevel});
  endtask : t_enable

  // Two dims past the floor must leave the level at the minimum
  task automatic t_dim();
    int e;
    for (int k = 1; k <= 34; k++) begin
      cmd(1);
      e = (33 - k < 1) ? 1 : 33 - k;
      check("pulseLevel dim", 8'(e), {2'b00, pulseLevel});
    end
  endtask : t_dim

  task automatic t_off();
    int start;
    start = cycles;
    cmd(2);
    while (cycles < start + SHUTDOWN_CYC + 20) @(negedge mclk);
    check("ledActive off", 8'h00, {7'h00, ledActive});
    check("pulseLevel off", 8'h00, {2'b00, pulseLevel});
    cmd(0);
    check("pulseLevel again", 8'h21, {2'b00, pulseLevel});
  endtask : t_off

  task automatic t_ovp();
    @(negedge mclk) overvoltageIn = 1'b1;
    @(negedge mclk) overvoltageIn = 1'b0;
    repeat (200) @(negedge mclk);
    check("latched", 8'h01, {7'h00, overvoltageLatched});
    check("ledActive latched", 8'h00, {7'h00, ledActive});
    cmd(1);
    repeat (ENABLE_MIN_CYC + SOFT_START_CYC + 50) @(negedge mclk);
    check("latched cleared", 8'h00, {7'h00, overvoltageLatched});
    check("pulseLevel restart", 8'h21, {2'b00, pulseLevel});
  endtask : t_ovp

  // Duty variant needs a fresh reset, since the variant is read in shutdown
  task automatic t_pwm();
    @(negedge mclk);
    resetn = 1'b0;
    pulseVariant = 1'b0;
    pwmMode = 1'b1;
    pwmDutyIn = 8'h80;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    cmd(0);
    repeat (3000) @(negedge mclk);
    check("pwmDuty half", 8'h01,
          {7'h00, pwmDuty >= 8'h7c && pwmDuty <= 8'h84});
    pwmDutyIn = 8'hff;
    repeat (ENABLE_MIN_CYC + 500) @(negedge mclk);
    check("pwmDuty full", DUTY_FULL, pwmDuty);
    pwmDutyIn = 8'h00;
    repeat (PWM_PER_MAX_CYC + 500) @(negedge mclk);
    check("pwmDuty zero", 8'h00, pwmDuty);
  endtask : t_pwm

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    t_enable();
    t_dim();
    t_off();
    t_ovp();
    t_pwm();
    summarize();
  end
endmodule : tb_top

`default_nettype wire
